// ==== psda_pkg.sv ====
// Package for the program space data access block
package psda_pkg;
	// ************************************************************
	// Widths and field positions
	// ************************************************************
	localparam int PROG_AW     = 24;
	localparam int DATA_W      = 16;
	localparam int PAGE_W      = 8;
	localparam int CFG_BIT     = 7;   // Table page bit that picks configuration space
	localparam int WIN_BIT     = 15;  // Effective address bit that opens the window
	localparam int WIN_LOW_W   = 15;
	localparam int CORE_CTL_W  = 16;
	localparam int CONST_WIN_B = 2;   // Window enable bit in core control

	// ************************************************************
	// Register map (byte addresses on the Wishbone bus)
	// ************************************************************
	localparam logic [3:0] OFS_TABLE_PAGE = 4'h0;
	localparam logic [3:0] OFS_VIS_PAGE   = 4'h4;
	localparam logic [3:0] OFS_CORE_CTL   = 4'h8;
	localparam logic [3:0] OFS_STATUS     = 4'hc;

	// Reset values
	localparam logic [7:0]  RST_TABLE_PAGE = 8'h00;
	localparam logic [7:0]  RST_VIS_PAGE   = 8'h00;
	localparam logic [15:0] RST_CORE_CTL   = 16'h0000;

	// ************************************************************
	// Extra cycle counts for window reads
	// ************************************************************
	localparam logic [1:0] EXTRA_NONE = 2'h0;
	localparam logic [1:0] EXTRA_MOVE = 2'h1;
	localparam logic [1:0] EXTRA_FULL = 2'h2;

	// Access kinds presented by the core
	typedef enum logic [2:0] {
		PSDA_IDLE  = 3'b000,
		PSDA_FETCH = 3'b001,
		PSDA_TRDL  = 3'b010,
		PSDA_TRDH  = 3'b011,
		PSDA_TWTL  = 3'b100,
		PSDA_TWTH  = 3'b101,
		PSDA_DREAD = 3'b110
	} psda_access_type;
endpackage : psda_pkg

// ==== psda_bridge.sv ====
// Program space data access bridge with Wishbone register slave
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module psda_bridge
	import psda_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// Wishbone slave
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [3:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	output logic                       wb_err_o,
	// Core request
	input  wire logic [2:0]            accessKind,
	input  wire logic                  byteMode,
	input  wire logic [22:0]           progCounter,
	input  wire logic [DATA_W-1:0]     effectiveAddress,
	input  wire logic [DATA_W-1:0]     writeData,
	input  wire logic                  moveInstr,
	input  wire logic                  inRepeat,
	input  wire logic                  repeatEdge,
	// Program memory side
	output logic      [PROG_AW-1:0]    progAddr,
	output logic                       progRead,
	output logic                       progWrite,
	output logic      [2:0]            progLaneEn,
	output logic      [PROG_AW-1:0]    progWdata,
	output logic                       configSpace,
	input  wire logic [PROG_AW-1:0]    progRdata,
	// Core result
	output logic      [DATA_W-1:0]     readData,
	output logic                       windowHit,
	output logic      [1:0]            extraCycles
);
	// ************************************************************
	// Registers
	// ************************************************************
	logic [PAGE_W-1:0]     tablePage_q;
	logic [PAGE_W-1:0]     visPage_q;
	logic [CORE_CTL_W-1:0] coreCtl_q;
	logic                  ack_q;
	logic [31:0]           rdat_q;
	logic                  err_q;

	// Bus decode
	wire busReq   = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
	wire hitTable = (wb_adr_i == OFS_TABLE_PAGE);
	wire hitVis   = (wb_adr_i == OFS_VIS_PAGE);
	wire hitCtl   = (wb_adr_i == OFS_CORE_CTL);
	wire hitStat  = (wb_adr_i == OFS_STATUS);
	wire mapped   = hitTable || hitVis || hitCtl || hitStat;
	// Writes land at the edge where ack is high, the edge the master takes the answer
	wire wrTake   = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
	wire wrLane0  = wrTake && wb_sel_i[0];
	wire wrLane1  = wrTake && wb_sel_i[1];

	// ************************************************************
	// Access decode
	// ************************************************************
	psda_access_type kind;
	assign kind = psda_access_type'(accessKind);

	wire isTable = (kind == PSDA_TRDL) || (kind == PSDA_TRDH)
		|| (kind == PSDA_TWTL) || (kind == PSDA_TWTH);
	wire byteSel = effectiveAddress[0];
	wire winEnable = coreCtl_q[CONST_WIN_B];
	wire winOn = (kind == PSDA_DREAD) && effectiveAddress[WIN_BIT] && winEnable && !isTable;

	wire [PROG_AW-1:0] fetchAddr = {1'b0, progCounter[22:1], 1'b0};
	wire [PROG_AW-1:0] tableAddr = {tablePage_q, effectiveAddress};
	wire [PROG_AW-1:0] winAddr = {1'b0, visPage_q, effectiveAddress[WIN_LOW_W-1:0]};

	// Address selection
	assign progAddr = (kind == PSDA_FETCH) ? fetchAddr :
		isTable ? tableAddr :
		winOn ? winAddr : '0;
	// space select from page top bit
	assign configSpace = isTable && tablePage_q[CFG_BIT];
	assign progRead = (kind == PSDA_FETCH) || (kind == PSDA_TRDL)
		|| (kind == PSDA_TRDH) || winOn;
	assign progWrite = (kind == PSDA_TWTL) || (kind == PSDA_TWTH);
	assign windowHit = winOn;

	// ************************************************************
	// Write steering
	// ************************************************************
	// lane enables for low and high writes
	assign progLaneEn = (kind == PSDA_TWTL) ?
		(byteMode ? (byteSel ? 3'b010 : 3'b001) : 3'b011) :
		(kind == PSDA_TWTH) ?
		((byteMode && byteSel) ? 3'b000 : 3'b100) : 3'b000;
	assign progWdata = (kind == PSDA_TWTL && byteMode) ?
		{8'h00, writeData[7:0], writeData[7:0]} :
		(kind == PSDA_TWTH) ? {writeData[7:0], 16'h0000} :
		{8'h00, writeData};

	// ************************************************************
	// Read steering
	// ************************************************************
	function automatic logic [DATA_W-1:0] steer(input psda_access_type k,
		input logic bm, input logic bs, input logic [PROG_AW-1:0] p);
		logic [DATA_W-1:0] r;
		r = '0;
		case (k)
			PSDA_TRDL:
				r = bm ? {8'h00, (bs ? p[15:8] : p[7:0])} : p[15:0];
			PSDA_TRDH:
				r = (bm && bs) ? 16'h0000 : {8'h00, p[23:16]};
			PSDA_DREAD:
				r = p[15:0];
			default:
				r = '0;
		endcase
		return r;
	endfunction : steer

	wire [DATA_W-1:0] rdNext = steer(kind, byteMode, byteSel, progRdata);
	wire readsProg = (kind == PSDA_TRDL) || (kind == PSDA_TRDH) || winOn;

	// ************************************************************
	// Stall cost of window reads
	// ************************************************************
	// extra cycle choice
	wire [1:0] extraNext = !winOn ? EXTRA_NONE :
		inRepeat ? (repeatEdge ? EXTRA_FULL : EXTRA_NONE) :
		moveInstr ? EXTRA_MOVE : EXTRA_FULL;

	// Result registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			readData    <= '0;
			extraCycles <= EXTRA_NONE;
		end
		else
		begin
			readData    <= readsProg ? rdNext : readData;
			extraCycles <= extraNext;
		end
	end

	// Configuration registers, only low lanes are meaningful
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tablePage_q <= RST_TABLE_PAGE;
			visPage_q   <= RST_VIS_PAGE;
			coreCtl_q   <= RST_CORE_CTL;
		end
		else
		begin
			if (wrLane0 && hitTable)
				tablePage_q <= wb_dat_i[7:0];
			if (wrLane0 && hitVis)
				visPage_q <= wb_dat_i[7:0];
			if (wrLane0 && hitCtl)
				coreCtl_q[7:0] <= wb_dat_i[7:0];
			if (wrLane1 && hitCtl)
				coreCtl_q[15:8] <= wb_dat_i[15:8];
		end
	end

	// Read mux; status shows the live access decode and the registered extra cycle count
	wire [31:0] rdMux = hitTable ? {24'h000000, tablePage_q} :
		hitVis ? {24'h000000, visPage_q} :
		hitCtl ? {16'h0000, coreCtl_q} :
		hitStat ? {27'h0000000, extraCycles, configSpace, winOn, isTable} :
		32'h00000000;

	// Single cycle answer; unmapped offsets get err instead of ack
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ack_q  <= 1'b0;
			err_q  <= 1'b0;
			rdat_q <= '0;
		end
		else
		begin
			ack_q  <= busReq && mapped;
			err_q  <= busReq && !mapped;
			rdat_q <= (busReq && !wb_we_i) ? rdMux : rdat_q;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_err_o = err_q;
	assign wb_dat_o = rdat_q;

	// ************************************************************
	// Checks
	// ************************************************************
	property p_fetch_align;
		@(posedge clk) disable iff (rst)
		(kind == PSDA_FETCH) |-> (progAddr[0] == 1'b0 && progAddr[23] == 1'b0
			&& progAddr[22:1] == progCounter[22:1]);
	endproperty
	a_fetch_align: assert property (p_fetch_align) else $error("fetch address wrong");

	property p_table_addr;
		@(posedge clk) disable iff (rst)
		isTable |-> (progAddr == {tablePage_q, effectiveAddress});
	endproperty
	a_table_addr: assert property (p_table_addr) else $error("table address wrong");

	property p_cfg_space;
		@(posedge clk) disable iff (rst)
		isTable |-> (configSpace == tablePage_q[7]);
	endproperty
	a_cfg_space: assert property (p_cfg_space) else $error("space select wrong");

	property p_high_phantom;
		@(posedge clk) disable iff (rst)
		(kind == PSDA_TRDH) |=> (readData[15:8] == 8'h00);
	endproperty
	a_high_phantom: assert property (p_high_phantom) else $error("phantom byte set");

	property p_low_word;
		@(posedge clk) disable iff (rst)
		(kind == PSDA_TRDL && !byteMode) |=> (readData == $past(progRdata[15:0]));
	endproperty
	a_low_word: assert property (p_low_word) else $error("low word read wrong");

	property p_win_gate;
		@(posedge clk) disable iff (rst)
		windowHit |-> (effectiveAddress[15] && coreCtl_q[2] && kind == PSDA_DREAD);
	endproperty
	a_win_gate: assert property (p_win_gate) else $error("window without cause");

	property p_win_addr;
		@(posedge clk) disable iff (rst)
		windowHit |-> (progAddr[15] == visPage_q[0] && progAddr[23] == 1'b0);
	endproperty
	a_win_addr: assert property (p_win_addr) else $error("window address wrong");

	property p_move_cost;
		@(posedge clk) disable iff (rst)
		(windowHit && !inRepeat && moveInstr) |=> (extraCycles == 2'h1);
	endproperty
	a_move_cost: assert property (p_move_cost) else $error("move cost wrong");

	property p_rep_cost;
		@(posedge clk) disable iff (rst)
		(windowHit && inRepeat) |=> (extraCycles == ($past(repeatEdge) ? 2'h2 : 2'h0));
	endproperty
	a_rep_cost: assert property (p_rep_cost) else $error("repeat cost wrong");

	property p_byte_high;
		@(posedge clk) disable iff (rst)
		(kind == PSDA_TRDH && byteMode && byteSel) |=> (readData == 16'h0000);
	endproperty
	a_byte_high: assert property (p_byte_high) else $error("high select not zero");

	property p_byte_low;
		@(posedge clk) disable iff (rst)
		(kind == PSDA_TRDL && byteMode) |=> (readData[15:8] == 8'h00);
	endproperty
	a_byte_low: assert property (p_byte_low) else $error("byte read upper not zero");

	property p_win_data;
		@(posedge clk) disable iff (rst)
		windowHit |=> (readData == $past(progRdata[15:0]));
	endproperty
	a_win_data: assert property (p_win_data) else $error("window data wrong");

	c_window: cover property (@(posedge clk) disable iff (rst) windowHit);
	c_cfg_read: cover property (@(posedge clk) disable iff (rst)
		kind == PSDA_TRDH && configSpace);
	c_bus_write: cover property (@(posedge clk) disable iff (rst) wb_ack_o && wb_we_i);
	c_repeat_edge: cover property (@(posedge clk) disable iff (rst)
		windowHit && inRepeat && repeatEdge);
	c_byte_write: cover property (@(posedge clk) disable iff (rst) progWrite && byteMode);
endmodule : psda_bridge

// ==== psda_prog_mem.sv ====
// Program memory array model facing the bridge
`timescale 1ns/1ps
module psda_prog_mem
	import psda_pkg::*;
(
	// Clock
	input  wire logic               clk,
	// Bridge side
	input  wire logic [PROG_AW-1:0] progAddr,
	input  wire logic               progRead,
	output logic      [PROG_AW-1:0] progRdata
);
	// ******************************
	// Read port
	// ******************************
	logic [PROG_AW-1:0] lastWord_q;
	logic [PROG_AW-1:0] cellWord;
	// Each cell holds a pattern made from its own address
	assign cellWord = {progAddr[7:0] ^ 8'ha5, progAddr[15:0] ^ 16'h3c96};
	// whole word offered
	// Idle port shows the inverse of the last word, so stale data never matches
	assign progRdata = progRead ? cellWord : ~lastWord_q;
	// Remember the last word driven
	always_ff @(posedge clk)
	begin
		if (progRead)
			lastWord_q <= cellWord;
	end
endmodule : psda_prog_mem

// ==== psda_bridge_test.sv ====
// Self-checking bench for the program space data access bridge
`timescale 1ns/1ps
module psda_bridge_test;
	import psda_pkg::*;
	// ******************************
	// Signals
	// ******************************
	localparam logic [7:0] TP = 8'h85;
	localparam logic [7:0] VP = 8'h3c;
	logic        clk, rst, wbCyc, wbStb, wbWe, wbAck, wbErr, errSeen;
	logic [3:0]  wbAdr;
	logic [31:0] wbDatW, wbDatR, rdv;
	logic [2:0]  accessKind, progLaneEn;
	logic        byteMode, moveInstr, inRepeat, repeatEdge;
	logic [22:0] progCounter;
	logic [15:0] effectiveAddress, writeData, readData, ea, e;
	logic [23:0] progAddr, progWdata, progRdata, p;
	logic        progRead, progWrite, configSpace, windowHit;
	logic [1:0]  extraCycles;
	logic [1:0]  exT [4] = '{2'h2, 2'h1, 2'h2, 2'h0};
	logic [2:0]  modeT [4] = '{3'b000, 3'b100, 3'b011, 3'b110};
	logic [2:0]  laneT [4] = '{3'b011, 3'b100, 3'b010, 3'b000};
	int          err_total, n_tests;

	psda_bridge psda_bridge_i (.clk(clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDatW),
		.wb_dat_o(wbDatR), .wb_ack_o(wbAck), .wb_err_o(wbErr), .accessKind(accessKind),
		.byteMode(byteMode), .progCounter(progCounter), .effectiveAddress(effectiveAddress),
		.writeData(writeData), .moveInstr(moveInstr), .inRepeat(inRepeat),
		.repeatEdge(repeatEdge), .progAddr(progAddr), .progRead(progRead),
		.progWrite(progWrite), .progLaneEn(progLaneEn), .progWdata(progWdata),
		.configSpace(configSpace), .progRdata(progRdata), .readData(readData),
		.windowHit(windowHit), .extraCycles(extraCycles));
	psda_prog_mem psda_prog_mem_i (.clk(clk), .progAddr(progAddr), .progRead(progRead),
		.progRdata(progRdata));

	// ******************************
	// Tasks
	// ******************************
	// Expected cell contents, same pattern the memory model holds
	function automatic logic [23:0] memW(input logic [23:0] a);
		return {a[7:0] ^ 8'ha5, a[15:0] ^ 16'h3c96};
	endfunction : memW
	// One comparison, counted
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			err_total++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Classic single Wishbone cycle; waits for ack or err, the watchdog ends a hang
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
		@(posedge clk);
		{wbCyc, wbStb, wbWe, wbAdr, wbDatW} <= {2'b11, we, adr, d};
		do
			@(posedge clk);
		while (wbAck !== 1'b1 && wbErr !== 1'b1);
		rdv = wbDatR;
		errSeen = wbErr;
		{wbCyc, wbStb} <= 2'b00;
	endtask : wb
	// Present one core access; combinational outputs are settled on return
	task automatic core(input logic [2:0] k, input logic bm, input logic [15:0] a,
		input logic [2:0] md);
		@(posedge clk);
		{accessKind, byteMode, effectiveAddress} <= {k, bm, a};
		{moveInstr, inRepeat, repeatEdge} <= md;
		#1;
	endtask : core
	// Let the registered results of the access land
	task automatic tick();
		@(posedge clk);
		#1;
	endtask : tick
	// Verdict and end of run
	task automatic conclude();
		$display("Comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude

	// ******************************
	// Clock, watchdog and sequence
	// ******************************
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Whole run needs under a hundred cycles
	initial
	begin
		#100000;
		err_total++;
		conclude();
	end
	initial
	begin
		{rst, wbCyc, wbStb, wbWe, wbAdr, wbDatW} = {4'b1000, 4'h0, 32'h0};
		{accessKind, byteMode, moveInstr, inRepeat, repeatEdge} = '0;
		{progCounter, effectiveAddress, writeData} = {23'h5abcdf, 16'h0, 16'hbe47};
		err_total = 0;
		n_tests = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		// Reset values, then write and read back, then an unmapped place
		wb(1'b0, OFS_TABLE_PAGE, 32'h0);
		chk("table page reset", RST_TABLE_PAGE, rdv);
		wb(1'b0, OFS_CORE_CTL, 32'h0);
		chk("core control reset", RST_CORE_CTL, rdv);
		wb(1'b1, OFS_TABLE_PAGE, {24'h000000, TP});
		wb(1'b1, OFS_VIS_PAGE, {24'h000000, VP});
		wb(1'b1, OFS_CORE_CTL, 32'h0004);
		wb(1'b0, OFS_VIS_PAGE, 32'h0);
		chk("visibility page", VP, rdv[7:0]);
		wb(1'b0, 4'h2, 32'h0);
		chk("unmapped error", 1'b1, errSeen);
		// Instruction fetch address
		core(PSDA_FETCH, 1'b0, 16'h0, 3'b0);
		chk("fetch address", {1'b0, progCounter[22:1], 1'b0}, progAddr);
		// Table reads in all four modes, odd and even byte addresses
		for (int i = 0; i < 8; i++)
		begin
			ea = 16'hd3a4 | 16'(i[0]);
			p = memW({TP, ea});
			core(i[2] ? PSDA_TRDH : PSDA_TRDL, i[1], ea, 3'b0);
			chk("table address", {TP, ea}, progAddr);
			chk("config space", TP[7], configSpace);
			chk("read strobe", 1'b1, progRead);
			chk("window during table", 1'b0, windowHit);
			tick();
			case ({i[2], i[1]})
				2'd0: e = p[15:0];
				2'd1: e = {8'h00, i[0] ? p[15:8] : p[7:0]};
				2'd2: e = {8'h00, p[23:16]};
				default: e = i[0] ? 16'h0 : {8'h00, p[23:16]};
			endcase
			chk("table read data", e, readData);
		end
		// Table writes, low and high, word mode and odd byte mode
		for (int i = 0; i < 4; i++)
		begin
			core(i[0] ? PSDA_TWTH : PSDA_TWTL, i[1], 16'h1234 | 16'(i[1]), 3'b0);
			chk("write strobe", 1'b1, progWrite);
			chk("write lanes", laneT[i], progLaneEn);
			chk("write data", i[0] ? writeData[7:0] : (i[1] ? writeData[7:0] : writeData),
				i[0] ? progWdata[23:16] : (i[1] ? progWdata[15:8] : progWdata[15:0]));
		end
		// Window reads with every cost case
		for (int i = 0; i < 4; i++)
		begin
			ea = 16'hc2e6 + 16'(i * 2);
			core(PSDA_DREAD, 1'b0, ea, modeT[i]);
			chk("window hit", 1'b1, windowHit);
			chk("window address", {1'b0, VP, ea[14:0]}, progAddr);
			tick();
			chk("window data", memW({1'b0, VP, ea[14:0]}) & 24'h00ffff, readData);
			chk("extra cycles", exT[i], extraCycles);
		end
		// Window stays shut below the upper half and when disabled
		core(PSDA_DREAD, 1'b0, 16'h42e6, 3'b0);
		chk("window low half", 1'b0, windowHit);
		wb(1'b1, OFS_CORE_CTL, 32'h0000);
		core(PSDA_DREAD, 1'b0, 16'hc2e6, 3'b0);
		chk("window disabled", 1'b0, windowHit);
		// User space page
		wb(1'b1, OFS_TABLE_PAGE, 32'h05);
		core(PSDA_TRDL, 1'b0, 16'h0010, 3'b0);
		chk("user space", 1'b0, configSpace);
		// Reset in mid-run clears the results and the page registers
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("read data after reset", 16'h0000, readData);
		chk("extra cycles after reset", EXTRA_NONE, extraCycles);
		wb(1'b0, OFS_VIS_PAGE, 32'h0);
		chk("visibility page reset", RST_VIS_PAGE, rdv);
		conclude();
	end
endmodule : psda_bridge_test
